// ==== bitband_remap.sv ====
// Bit-band alias remapper between a bus master and the memory system.
`timescale 1ns/10ps
`include "bitband_defines.svh"
module bitband_remap (
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire bitband_pkg::req_t  i_req,
  output logic                    o_req_ready,
  output bitband_pkg::rsp_t       o_rsp,
  output logic                    o_rsp_err,
  output bitband_pkg::mreq_t      o_mem,
  input  wire bitband_pkg::rsp_t  i_mem_rsp
);

  // ==========================================================================
  // Alias decode
  // ==========================================================================
  logic                  in_sram_alias;
  logic                  in_peri_alias;
  logic                  in_alias;
  logic [31:0]           band_addr;
  logic [2:0]            bit_sel;
  bitband_pkg::state_t   state_r;
  bitband_pkg::req_t     req_r;
  logic [2:0]            bit_r;
  logic                  wbit_r;

  always_comb begin
    in_sram_alias = (i_req.addr[31:`ALIAS_SEL_LSB] ==
                     7'(`SRAM_ALIAS_BASE >> `ALIAS_SEL_LSB));
    in_peri_alias = (i_req.addr[31:`ALIAS_SEL_LSB] ==
                     7'(`PERI_ALIAS_BASE >> `ALIAS_SEL_LSB));
    in_alias = (in_sram_alias || in_peri_alias) && !i_req.instr;
    // Inverse of offset = byte*32 + bit*4: byte index from bits 24:5.
    band_addr = (in_sram_alias ? `SRAM_BAND_BASE : `PERI_BAND_BASE) |
                {12'h000, i_req.addr[`BAND_OFFS_MSB+`ALIAS_BYTE_LSB:
                                     `ALIAS_BYTE_LSB]};
    bit_sel = i_req.addr[`ALIAS_BIT_LSB +: 3];
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  wire take = i_req.valid && (state_r == bitband_pkg::ST_IDLE);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_r <= bitband_pkg::ST_IDLE;
    end else begin
      case (state_r)
        bitband_pkg::ST_IDLE: begin
          if (i_req.valid) begin
            if (i_req.instr && in_peri_alias) begin
              state_r <= bitband_pkg::ST_FAULT;
            end else if (in_alias) begin
              state_r <= bitband_pkg::ST_RD;
            end else begin
              state_r <= bitband_pkg::ST_PASS;
            end
          end
        end
        bitband_pkg::ST_PASS: begin
          if (i_mem_rsp.valid) begin
            state_r <= bitband_pkg::ST_IDLE;
          end
        end
        bitband_pkg::ST_RD: begin
          if (i_mem_rsp.valid) begin
            state_r <= req_r.write ? bitband_pkg::ST_WR
                                   : bitband_pkg::ST_IDLE;
          end
        end
        bitband_pkg::ST_WR: begin
          if (i_mem_rsp.valid) begin
            state_r <= bitband_pkg::ST_IDLE;
          end
        end
        bitband_pkg::ST_FAULT: begin
          state_r <= bitband_pkg::ST_IDLE;
        end
        default: begin
          state_r <= bitband_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      req_r  <= '0;
      bit_r  <= 3'h0;
      wbit_r <= 1'b0;
    end else if (take) begin
      req_r  <= i_req;
      bit_r  <= bit_sel;
      wbit_r <= i_req.wdata[0];
      if (in_alias) begin
        req_r.addr <= band_addr;
      end
    end
  end

  // ==========================================================================
  // Memory side
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_mem <= '0;
    end else if (take && !(i_req.instr && in_peri_alias)) begin
      o_mem.valid <= 1'b1;
      o_mem.write <= i_req.write && !in_alias;
      o_mem.size  <= in_alias ? bitband_pkg::SZ_BYTE : i_req.size;
      o_mem.addr  <= in_alias ? band_addr : i_req.addr;
      o_mem.wdata <= i_req.wdata;
    end else if (state_r == bitband_pkg::ST_RD && i_mem_rsp.valid &&
                 req_r.write) begin
      // Rewrite the whole byte with only the targeted bit changed.
      o_mem.valid <= 1'b1;
      o_mem.write <= 1'b1;
      o_mem.size  <= bitband_pkg::SZ_BYTE;
      o_mem.addr  <= req_r.addr;
      o_mem.wdata <= {4{i_mem_rsp.rdata[8*req_r.addr[1:0] +: 8] &
                        ~(8'h01 << bit_r) |
                        ({7'h00, wbit_r} << bit_r)}};
    end else begin
      o_mem.valid <= 1'b0;
    end
  end

  // ==========================================================================
  // Master side
  // ==========================================================================
  logic rd_bit;
  always_comb begin
    rd_bit = i_mem_rsp.rdata[{req_r.addr[1:0], bit_r}];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rsp       <= '0;
      o_rsp_err   <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      o_rsp.valid <= 1'b0;
      o_rsp_err   <= 1'b0;
      o_req_ready <= 1'b0;
      case (state_r)
        bitband_pkg::ST_PASS: begin
          if (i_mem_rsp.valid) begin
            o_rsp.valid <= 1'b1;
            o_rsp.rdata <= i_mem_rsp.rdata;
            o_req_ready <= 1'b1;
          end
        end
        bitband_pkg::ST_RD: begin
          if (i_mem_rsp.valid && !req_r.write) begin
            o_rsp.valid <= 1'b1;
            o_rsp.rdata <= rd_bit ? `ALIAS_READ_ONE
                                  : `ALIAS_READ_ZERO;
            o_req_ready <= 1'b1;
          end
        end
        bitband_pkg::ST_WR: begin
          if (i_mem_rsp.valid) begin
            o_rsp.valid <= 1'b1;
            o_rsp.rdata <= `ALIAS_READ_ZERO;
            o_req_ready <= 1'b1;
          end
        end
        bitband_pkg::ST_FAULT: begin
          // A refused fetch never carries stale data back to the master.
          o_rsp.valid <= 1'b1;
          o_rsp.rdata <= `ALIAS_READ_ZERO;
          o_rsp_err   <= 1'b1;
          o_req_ready <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking chk_cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_ALIAS_BYTE: assert property (
    take && in_alias |=> o_mem.valid && o_mem.size == bitband_pkg::SZ_BYTE
      && !o_mem.write)
    else $error("Alias access did not start with a byte read.");
  AST_ALIAS_ADDR: assert property (
    take && in_alias |=>
      o_mem.addr[31:25] == $past(i_req.addr[31:25]) - 7'h01
      && o_mem.addr[24:20] == 5'h00
      && o_mem.addr[19:0] == $past(i_req.addr[24:5]))
    else $error("Alias address mapped wrongly.");
  AST_PASS_ADDR: assert property (
    take && !in_alias && !(i_req.instr && in_peri_alias) |=>
      o_mem.addr == $past(i_req.addr) && o_mem.size == $past(i_req.size)
      && o_mem.write == $past(i_req.write))
    else $error("Direct access was altered.");
  AST_PASS_DATA: assert property (
    take && !in_alias && !(i_req.instr && in_peri_alias) |=>
      o_mem.valid && o_mem.wdata == $past(i_req.wdata))
    else $error("Forwarded write data changed.");
  AST_SRAM_FETCH: assert property (
    take && in_sram_alias && i_req.instr |=> o_mem.addr == $past(i_req.addr))
    else $error("Instruction fetch was remapped.");
  AST_PERI_FETCH: assert property (
    take && in_peri_alias && i_req.instr |=> !o_mem.valid ##1 o_rsp_err)
    else $error("Peripheral alias fetch not refused.");
  AST_READ_VAL: assert property (
    o_rsp.valid && $past(state_r == bitband_pkg::ST_RD) |->
      o_rsp.rdata[31:1] == 31'h0)
    else $error("Alias read returned upper bits.");
  AST_RMW_WRITE: assert property (
    state_r == bitband_pkg::ST_RD && i_mem_rsp.valid && req_r.write |=>
      o_mem.valid && o_mem.write && o_mem.wdata[{req_r.addr[1:0], bit_r}]
      == wbit_r)
    else $error("Read-modify-write lost the data bit.");
  AST_RMW_KEEP: assert property (
    state_r == bitband_pkg::ST_RD && i_mem_rsp.valid && req_r.write |=>
      ((o_mem.wdata[8*req_r.addr[1:0] +: 8] ^
        $past(i_mem_rsp.rdata[8*req_r.addr[1:0] +: 8])) & ~(8'h01 << bit_r))
        == 8'h00)
    else $error("Other bits changed by alias write.");
  AST_BIT_RANGE: assert property (
    take |=> bit_r == $past(i_req.addr[4:2]))
    else $error("Bit number taken from wrong field.");

  COV_ALIAS_RD: cover property (take && in_alias && !i_req.write);
  COV_ALIAS_WR: cover property (take && in_alias && i_req.write);
  COV_PASS: cover property (take && !in_alias);
  COV_FAULT: cover property (o_rsp_err);

endmodule

// ==== bitband_defines.svh ====
// Address constants and read values for the bit-band alias remapper.
`ifndef BITBAND_DEFINES_SVH
`define BITBAND_DEFINES_SVH
`define SRAM_ALIAS_BASE   32'h2200_0000
`define SRAM_BAND_BASE    32'h2000_0000
`define PERI_ALIAS_BASE   32'h4200_0000
`define PERI_BAND_BASE    32'h4000_0000
`define ALIAS_WIN_MSB     7'h7F
`define ALIAS_SEL_LSB     25
`define ALIAS_BYTE_LSB    5
`define ALIAS_BIT_LSB     2
`define BAND_OFFS_MSB     19
`define ALIAS_READ_ONE    32'h0000_0001
`define ALIAS_READ_ZERO   32'h0000_0000
`endif

// ==== bitband_pkg.sv ====
// Types shared by the bit-band alias remapper.
package bitband_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } size_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        instr;
    size_t       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    size_t       size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mreq_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } rsp_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_PASS   = 5'h02,
    ST_RD     = 5'h04,
    ST_WR     = 5'h08,
    ST_FAULT  = 5'h10
  } state_t;
endpackage

// ==== bitband_mem_model.sv ====
// Memory partner that answers every memory request once, fast or slow.
`timescale 1ns/10ps
module bitband_mem_model (
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_slow,
  input  wire bitband_pkg::mreq_t i_mem,
  output bitband_pkg::rsp_t       o_rsp
);
  logic [31:0] mem_r [16] = '{default: 32'h0};
  logic [31:0] addr_r;
  logic        pend_r;
  logic [1:0]  wait_r;
  logic [3:0]  idx;
  logic [3:0]  ridx;

  assign idx  = {i_mem.addr[30], i_mem.addr[4:2]};
  assign ridx = {addr_r[30], addr_r[4:2]};

  // Outside an answer the data lines invert every cycle; reset holds them at zero.
  always @(posedge i_core_clk) begin
    o_rsp.valid <= 1'h0;
    o_rsp.rdata <= ~o_rsp.rdata;
    if (i_sys_rst) begin
      pend_r      <= 1'h0;
      o_rsp.rdata <= 32'h0;
    end else if (i_mem.valid === 1'h1) begin
      pend_r <= 1'h1;
      wait_r <= i_slow ? 2'h3 : 2'h0;
      addr_r <= i_mem.addr;
      for (int b = 0; b < 4; b++) begin
        if (i_mem.write && (i_mem.size == bitband_pkg::SZ_WORD
            || (i_mem.size == bitband_pkg::SZ_HALF
                && 1'(b >> 1) == i_mem.addr[1])
            || 2'(b) == i_mem.addr[1:0])) begin
          mem_r[idx][8*b +: 8] <= i_mem.wdata[8*b +: 8];
        end
      end
    end else if (pend_r) begin
      if (wait_r == 2'h0) begin
        o_rsp.valid <= 1'h1;
        o_rsp.rdata <= mem_r[ridx];
        pend_r      <= 1'h0;
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule

// ==== bitband_remap_tb.sv ====
// Self-checking testbench for the bit-band alias remapper.
`timescale 1ns/10ps
module bitband_remap_tb;
  localparam bitband_pkg::size_t B = bitband_pkg::SZ_BYTE;
  localparam bitband_pkg::size_t H = bitband_pkg::SZ_HALF;
  localparam bitband_pkg::size_t W = bitband_pkg::SZ_WORD;
  // Op 0 reads, 1 writes, 2 fetches; a memory address of 0 means refused.
  typedef struct packed {
    logic [1:0]         op;
    bitband_pkg::size_t sz;
    logic [31:0]        addr;
    logic [31:0]        wdata;
    logic [31:0]        rdata;
    logic [31:0]        maddr;
    bitband_pkg::size_t msz;
  } row_t;

  logic               i_core_clk;
  logic               i_sys_rst;
  logic               slow;
  bitband_pkg::req_t  req;
  logic               req_ready;
  bitband_pkg::rsp_t  rsp;
  logic               rsp_err;
  bitband_pkg::mreq_t mem;
  bitband_pkg::rsp_t  mem_rsp;
  logic [31:0]        last_addr;
  bitband_pkg::size_t last_size;
  row_t               rows[$];
  int                 mismatches;
  int                 checks;

  bitband_remap dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_req(req), .o_req_ready(req_ready), .o_rsp(rsp),
    .o_rsp_err(rsp_err), .o_mem(mem), .i_mem_rsp(mem_rsp));
  bitband_mem_model mem_model (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_slow(slow), .i_mem(mem), .o_rsp(mem_rsp));

  always #5 i_core_clk = ~i_core_clk;

  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic add(input logic [1:0] op, input bitband_pkg::size_t sz,
      input logic [31:0] a, input logic [31:0] wd, input logic [31:0] rd,
      input logic [31:0] ma, input bitband_pkg::size_t ms);
    rows.push_back('{op, sz, a, wd, rd, ma, ms});
  endtask

  // The request is dropped in the cycle that shows the ready pulse.
  task automatic run(input row_t r);
    int n;
    @(posedge i_core_clk);
    #1;
    last_addr = 32'h0;
    req = '{1'h1, r.op == 2'h1, r.op == 2'h2, r.sz, r.addr, r.wdata};
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      n++;
      if (mem.valid === 1'h1) begin
        last_addr = mem.addr;
        last_size = mem.size;
      end
    end while (req_ready !== 1'h1 && n < 200);
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
    req.valid = 1'h0;
    check("rsp_valid", 32'(rsp.valid), 32'h1);
    if (r.op == 2'h0 || r.maddr == 32'h0) begin
      check("rdata", rsp.rdata, r.rdata);
    end
    check("rsp_err", 32'(rsp_err), 32'(r.maddr == 32'h0));
    check("mem_addr", last_addr, r.maddr);
    if (r.maddr != 32'h0) begin
      check("mem_size", 32'(last_size), 32'(r.msz));
    end
  endtask

  initial begin
    i_core_clk = 1'h0;
    i_sys_rst  = 1'h1;
    slow       = 1'h0;
    req        = '0;
    mismatches = 0;
    checks     = 0;
    add(2'h1, W, 32'h2000_0000, 32'h1234_56A5, 32'h0, 32'h2000_0000, W);
    add(2'h0, W, 32'h2200_0000, 32'h0, 32'h1, 32'h2000_0000, B);
    add(2'h0, W, 32'h2200_0004, 32'h0, 32'h0, 32'h2000_0000, B);
    add(2'h0, W, 32'h2200_001C, 32'h0, 32'h1, 32'h2000_0000, B);
    add(2'h1, W, 32'h2200_0004, 32'hFFFF_FFFF, 32'h0, 32'h2000_0000, B);
    add(2'h1, W, 32'h2200_0000, 32'h0000_000E, 32'h0, 32'h2000_0000, B);
    add(2'h0, W, 32'h2000_0000, 32'h0, 32'h1234_56A6, 32'h2000_0000, W);
    add(2'h0, W, 32'h2200_0028, 32'h0, 32'h1, 32'h2000_0001, B);
    add(2'h1, W, 32'h23FF_FFFC, 32'h1, 32'h0, 32'h200F_FFFF, B);
    add(2'h0, W, 32'h23FF_FFFC, 32'h0, 32'h1, 32'h200F_FFFF, B);
    add(2'h0, W, 32'h23FF_FFE0, 32'h0, 32'h0, 32'h200F_FFFF, B);
    add(2'h1, W, 32'h4000_0004, 32'h0000_8000, 32'h0, 32'h4000_0004, W);
    add(2'h0, W, 32'h4200_00BC, 32'h0, 32'h1, 32'h4000_0005, B);
    add(2'h1, W, 32'h4200_00B8, 32'h1, 32'h0, 32'h4000_0005, B);
    add(2'h0, W, 32'h4000_0004, 32'h0, 32'h0000_C000, 32'h4000_0004, W);
    add(2'h2, W, 32'h4200_0000, 32'h0, 32'h0, 32'h0, W);
    add(2'h2, W, 32'h2200_0000, 32'h0, 32'h0, 32'h2200_0000, W);
    add(2'h1, W, 32'h6000_0010, 32'hCAFE_F00D, 32'h0, 32'h6000_0010, W);
    add(2'h0, H, 32'h6000_0012, 32'h0, 32'hCAFE_F00D, 32'h6000_0012, H);
    repeat (6) @(posedge i_core_clk);
    #1 i_sys_rst = 1'h0;
    for (int p = 0; p < 2; p++) begin
      slow = 1'(p);
      foreach (rows[i]) run(rows[i]);
    end
    // A reset in the middle of an alias write must leave the block idle.
    @(posedge i_core_clk);
    #1;
    req = '{1'h1, 1'h1, 1'h0, W, 32'h2200_0004, 32'h1};
    repeat (2) @(posedge i_core_clk);
    #1;
    i_sys_rst = 1'h1;
    req.valid = 1'h0;
    repeat (6) @(posedge i_core_clk);
    #1 i_sys_rst = 1'h0;
    @(posedge i_core_clk);
    #1;
    check("ready_after_reset", 32'(req_ready), 32'h0);
    check("rsp_after_reset", 32'(rsp.valid), 32'h0);
    check("mem_after_reset", 32'(mem.valid), 32'h0);
    // Restore the byte, set bit one, clear bit zero, then read it whole.
    run(rows[0]);
    run(rows[4]);
    run(rows[5]);
    run(rows[6]);
    print_verdict();
  end
endmodule
